// ---- src/bgcs_pkg.sv ----
// Shared constants for the bank group command spacing checker.
// Assumes a single 200 MHz command clock; all gaps are counted in its cycles.
package bgcs_pkg;

  // Clock period in picoseconds, used to turn printed times into cycles.
  localparam int CLK_PERIOD_PS = 5000;

  // Width of the saturating age timers and their saturated value.
  localparam int TIMER_W = 8;
  localparam logic [TIMER_W-1:0] TIMER_SAT = 8'hff;

  // Command codes seen on the decoded command port.
  typedef enum logic [1:0] {
    CMD_NOP = 2'h0,
    CMD_ACT = 2'h1,
    CMD_RD = 2'h2,
    CMD_WR = 2'h3
  } bgcs_cmd_e;

  // Least time rounded up to whole cycles, never below one cycle.
  function automatic int cyc_ceil(input int ps);
    int c;
    c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  // Where a gap has both a cycle figure and a time, the longer one holds.
  function automatic int gap_max(input int nck, input int ps);
    int c;
    c = cyc_ceil(ps);
    return (nck > c) ? nck : c;
  endfunction

  // Column to column gaps in cycles.
  localparam int COL_S_NCK = 4;
  localparam int COL_L_NCK = 6;

  // Activate to activate gaps: cycle figure and times per page size.
  localparam int ACT_NCK = 4;
  localparam int ACT_S_SMALL_PS = 3300;
  localparam int ACT_S_2K_PS = 5300;
  localparam int ACT_L_SMALL_PS = 4900;
  localparam int ACT_L_2K_PS = 6400;
  localparam logic [TIMER_W-1:0] ACT_S_SMALL_CYC = 8'(gap_max(ACT_NCK, ACT_S_SMALL_PS));
  localparam logic [TIMER_W-1:0] ACT_S_2K_CYC = 8'(gap_max(ACT_NCK, ACT_S_2K_PS));
  localparam logic [TIMER_W-1:0] ACT_L_SMALL_CYC = 8'(gap_max(ACT_NCK, ACT_L_SMALL_PS));
  localparam logic [TIMER_W-1:0] ACT_L_2K_CYC = 8'(gap_max(ACT_NCK, ACT_L_2K_PS));

  // Write to read gaps, counted from the start of the internal write.
  localparam int WTR_S_NCK = 2;
  localparam int WTR_S_PS = 2500;
  localparam int WTR_L_NCK = 4;
  localparam int WTR_L_PS = 7500;
  localparam logic [TIMER_W-1:0] WTR_S_CYC = 8'(gap_max(WTR_S_NCK, WTR_S_PS));
  localparam logic [TIMER_W-1:0] WTR_L_CYC = 8'(gap_max(WTR_L_NCK, WTR_L_PS));

  // An eight-beat burst occupies four clocks of the data bus.
  localparam logic [TIMER_W-1:0] BURST8_CLKS = 8'h04;

  // Default four-activate window length in cycles.
  localparam int FAW_DEFAULT_NCK = 20;

  // Timer value loaded on the cycle a command is seen.
  localparam logic [TIMER_W-1:0] TIMER_HIT = 8'h01;

endpackage

// ---- src/bgcs_group_timer.sv ----
// Per bank group age timers: cycles since the last column, activate and
// write command to this group. Assumes one command at most per cycle.
`timescale 1ns/100ps
module bgcs_group_timer (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_b,
  // Command hits for this group.
  input wire logic hit_col,
  input wire logic hit_act,
  input wire logic hit_wr,
  // Ages, saturating; the saturated value means no recent command.
  output logic [bgcs_pkg::TIMER_W-1:0] since_col_ff,
  output logic [bgcs_pkg::TIMER_W-1:0] since_act_ff,
  output logic [bgcs_pkg::TIMER_W-1:0] since_wr_ff
);
  import bgcs_pkg::*;

  logic [TIMER_W-1:0] nxt_since_col; // Next column age.
  logic [TIMER_W-1:0] nxt_since_act; // Next activate age.
  logic [TIMER_W-1:0] nxt_since_wr; // Next write age.

  // A hit loads one so the age equals the distance to a later command.
  always_comb begin
    nxt_since_col = hit_col ? TIMER_HIT :
                    (since_col_ff == TIMER_SAT) ? TIMER_SAT : since_col_ff + TIMER_HIT;
    nxt_since_act = hit_act ? TIMER_HIT :
                    (since_act_ff == TIMER_SAT) ? TIMER_SAT : since_act_ff + TIMER_HIT;
    nxt_since_wr = hit_wr ? TIMER_HIT :
                   (since_wr_ff == TIMER_SAT) ? TIMER_SAT : since_wr_ff + TIMER_HIT;
  end

  // Registers start saturated so the first command is never flagged.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      since_col_ff <= TIMER_SAT;
      since_act_ff <= TIMER_SAT;
      since_wr_ff <= TIMER_SAT;
    end else begin
      since_col_ff <= nxt_since_col;
      since_act_ff <= nxt_since_act;
      since_wr_ff <= nxt_since_wr;
    end
  end

endmodule

// ---- src/bgcs_spacing.sv ----
// Device-side bank group spacing checker with read strobe release timing.
// Assumes decoded commands arrive one per clock, synchronous to clock.
`timescale 1ns/100ps
module bgcs_spacing #(
  parameter int COL_S_CYC = bgcs_pkg::COL_S_NCK, // Short column gap.
  parameter int COL_L_CYC = bgcs_pkg::COL_L_NCK, // Long column gap.
  parameter int FAW_CYC = bgcs_pkg::FAW_DEFAULT_NCK // Four-activate window.
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_b,
  // Decoded command port.
  input wire logic cmd_valid,
  input wire bgcs_pkg::bgcs_cmd_e cmd_op,
  input wire logic [1:0] group_select,
  input wire logic [1:0] bank_select,
  // Configuration levels.
  input wire logic x16_mode,
  input wire logic page_2k,
  input wire logic preamble_2t,
  input wire logic dll_locked,
  input wire logic [5:0] read_latency_cycles,
  input wire logic [5:0] write_latency_cycles,
  // Decoded bank location of the last command.
  output logic [1:0] group_index_ff,
  output logic [3:0] bank_index_ff,
  // Spacing violation pulses, one cycle after the offending command.
  output logic col_gap_err_ff,
  output logic act_gap_err_ff,
  output logic wr_to_rd_err_ff,
  output logic faw_err_ff,
  // Read strobe drive; enable is low while the strobe is driven.
  output logic strobe_oe_b_ff,
  output logic strobe_release_ff
);
  import bgcs_pkg::*;

  localparam int NGRP = 4; // Group slots; x16 uses the lower two.

  // Gaps that the eight-bit age timers cannot count are refused at elaboration,
  // since a gap at the saturated age would never be flagged.
  if (COL_S_CYC < 1 || COL_L_CYC < COL_S_CYC || COL_L_CYC > 254 || FAW_CYC < 1 ||
      FAW_CYC > 254) begin : g_bad_params
    $error("bgcs_spacing: gap parameters out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command decode and per-group timers.

  logic col_go; // Read or write accepted this cycle.
  logic act_go; // Activate accepted this cycle.
  logic rd_go; // Read accepted this cycle.
  logic wr_go; // Write accepted this cycle.
  logic [1:0] eff_grp; // Group after organisation folding.
  logic [TIMER_W-1:0] col_age [NGRP]; // Column age per group.
  logic [TIMER_W-1:0] act_age [NGRP]; // Activate age per group.
  logic [TIMER_W-1:0] wr_age [NGRP]; // Write age per group.

  assign col_go = cmd_valid && (cmd_op == CMD_RD || cmd_op == CMD_WR);
  assign act_go = cmd_valid && (cmd_op == CMD_ACT);
  assign rd_go = cmd_valid && (cmd_op == CMD_RD);
  assign wr_go = cmd_valid && (cmd_op == CMD_WR);
  // A x16 part has one group bit; the upper bit is ignored, not trusted.
  assign eff_grp = x16_mode ? {1'b0, group_select[0]} : group_select;

  // One timer set per group keeps the last command per group.
  for (genvar g = 0; g < NGRP; g++) begin : g_grp
    bgcs_group_timer u_timer (
      .clock(clock),
      .rst_b(rst_b),
      .hit_col(col_go && eff_grp == 2'(g)),
      .hit_act(act_go && eff_grp == 2'(g)),
      .hit_wr(wr_go && eff_grp == 2'(g)),
      .since_col_ff(col_age[g]),
      .since_act_ff(act_age[g]),
      .since_wr_ff(wr_age[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Gap selection and comparison.

  logic [TIMER_W-1:0] col_s_gap; // Short column gap after preamble rounding.
  logic [TIMER_W-1:0] col_l_gap; // Long column gap after preamble rounding.
  logic [TIMER_W-1:0] act_s_gap; // Short activate gap for this page size.
  logic [TIMER_W-1:0] act_l_gap; // Long activate gap for this page size.
  logic [TIMER_W-1:0] wtr_s_need; // Write command to read, other group.
  logic [TIMER_W-1:0] wtr_l_need; // Write command to read, same group.
  logic col_bad; // Column spacing broken.
  logic act_bad; // Activate spacing broken.
  logic wtr_bad; // Write to read spacing broken.

  // Odd column gaps gain one cycle under the two-cycle write preamble.
  always_comb begin
    col_s_gap = 8'(COL_S_CYC) + ((preamble_2t && COL_S_CYC[0]) ? 8'h01 : 8'h00);
    col_l_gap = 8'(COL_L_CYC) + ((preamble_2t && COL_L_CYC[0]) ? 8'h01 : 8'h00);
    act_s_gap = page_2k ? ACT_S_2K_CYC : ACT_S_SMALL_CYC;
    act_l_gap = page_2k ? ACT_L_2K_CYC : ACT_L_SMALL_CYC;
    // The internal write starts after write latency plus the burst.
    wtr_s_need = {2'h0, write_latency_cycles} + BURST8_CLKS + WTR_S_CYC;
    wtr_l_need = {2'h0, write_latency_cycles} + BURST8_CLKS + WTR_L_CYC;
  end

  // Same group uses the long figure, every other group the short one.
  always_comb begin
    col_bad = 1'b0;
    act_bad = 1'b0;
    wtr_bad = 1'b0;
    for (int g = 0; g < NGRP; g++) begin
      if (eff_grp == 2'(g)) begin
        col_bad = col_bad || (col_age[g] < col_l_gap);
        act_bad = act_bad || (act_age[g] < act_l_gap);
        wtr_bad = wtr_bad || (wr_age[g] < wtr_l_need);
      end else begin
        col_bad = col_bad || (col_age[g] < col_s_gap);
        act_bad = act_bad || (act_age[g] < act_s_gap);
        wtr_bad = wtr_bad || (wr_age[g] < wtr_s_need);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Four-activate window: ages of the last four activates, newest first.

  logic [TIMER_W-1:0] faw_age_ff [4]; // Ages of recent activates.
  logic [TIMER_W-1:0] nxt_faw_age [4]; // Next ages.
  logic faw_bad; // A fifth activate inside the window.

  // The oldest of four must have left the window before a new one.
  always_comb begin
    faw_bad = act_go && (faw_age_ff[3] < 8'(FAW_CYC));
    for (int i = 0; i < 4; i++) begin
      nxt_faw_age[i] = (faw_age_ff[i] == TIMER_SAT) ? TIMER_SAT : faw_age_ff[i] + TIMER_HIT;
    end
    if (act_go) begin
      nxt_faw_age[0] = TIMER_HIT;
      for (int i = 1; i < 4; i++) begin
        nxt_faw_age[i] = (faw_age_ff[i-1] == TIMER_SAT) ? TIMER_SAT :
                         faw_age_ff[i-1] + TIMER_HIT;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 4; i++) begin
        faw_age_ff[i] <= TIMER_SAT;
      end
    end else begin
      faw_age_ff <= nxt_faw_age;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags and decoded location.

  logic nxt_col_err; // Next column error pulse.
  logic nxt_act_err; // Next activate error pulse.
  logic nxt_wtr_err; // Next write to read error pulse.
  logic [1:0] nxt_group_index; // Next group index.
  logic [3:0] nxt_bank_index; // Next flat bank index.

  // Pulses last one cycle; the location holds until the next command.
  always_comb begin
    nxt_col_err = col_go && col_bad;
    nxt_act_err = act_go && act_bad;
    nxt_wtr_err = rd_go && wtr_bad;
    nxt_group_index = cmd_valid ? eff_grp : group_index_ff;
    nxt_bank_index = cmd_valid ? {eff_grp, bank_select} : bank_index_ff;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      col_gap_err_ff <= 1'b0;
      act_gap_err_ff <= 1'b0;
      wr_to_rd_err_ff <= 1'b0;
      faw_err_ff <= 1'b0;
      group_index_ff <= 2'h0;
      bank_index_ff <= 4'h0;
    end else begin
      col_gap_err_ff <= nxt_col_err;
      act_gap_err_ff <= nxt_act_err;
      wr_to_rd_err_ff <= nxt_wtr_err;
      faw_err_ff <= faw_bad;
      group_index_ff <= nxt_group_index;
      bank_index_ff <= nxt_bank_index;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read strobe: driven for the burst, released at latency plus four.

  logic [6:0] rd_cnt_ff; // Cycles left until release, plus one.
  logic [6:0] nxt_rd_cnt; // Next count.
  logic nxt_strobe_oe_b; // Next drive enable, low drives.
  logic nxt_strobe_release; // Next release pulse.

  // Without a locked loop the timing is void, so the burst is dropped.
  // A new read restarts the count; overlapping bursts are not merged.
  always_comb begin
    if (!dll_locked) begin
      nxt_rd_cnt = 7'h00;
    end else if (rd_go) begin
      nxt_rd_cnt = {1'b0, read_latency_cycles} + 7'h04;
    end else if (rd_cnt_ff != 7'h00) begin
      nxt_rd_cnt = rd_cnt_ff - 7'h01;
    end else begin
      nxt_rd_cnt = 7'h00;
    end
    nxt_strobe_oe_b = !(dll_locked && rd_cnt_ff >= 7'h03 && rd_cnt_ff <= 7'h06);
    nxt_strobe_release = dll_locked && (rd_cnt_ff == 7'h02);
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rd_cnt_ff <= 7'h00;
      strobe_oe_b_ff <= 1'b1;
      strobe_release_ff <= 1'b0;
    end else begin
      rd_cnt_ff <= nxt_rd_cnt;
      strobe_oe_b_ff <= nxt_strobe_oe_b;
      strobe_release_ff <= nxt_strobe_release;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions and covers.

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  a_col_same_group: assert property (
    col_go ##2 (col_go && eff_grp == $past(eff_grp, 2)) |=> col_gap_err_ff)
    else $error("column gap in same group not flagged");
  a_col_other_group: assert property (
    col_go ##3 (col_go && eff_grp != $past(eff_grp, 3)) |=> col_gap_err_ff)
    else $error("column gap to other group not flagged");
  a_col_clean_gap: assert property (
    (col_go ##1 (!cmd_valid)[*8] ##1 col_go) |=> !col_gap_err_ff)
    else $error("wide column gap flagged");
  a_act_short_gap: assert property (
    act_go ##3 act_go |=> act_gap_err_ff)
    else $error("activate gap not flagged");
  a_wr_rd_gap: assert property (
    wr_go ##2 (rd_go && eff_grp == $past(eff_grp, 2)) |=> wr_to_rd_err_ff)
    else $error("write to read gap not flagged");
  a_faw_cause: assert property (
    faw_err_ff |-> $past(act_go) && $past(faw_age_ff[3]) < 8'(FAW_CYC))
    else $error("window error without fifth activate");
  a_x16_group: assert property (
    (cmd_valid && x16_mode) |=> !group_index_ff[1] && !bank_index_ff[3])
    else $error("x16 group uses upper bit");
  a_dll_quiet: assert property (
    !dll_locked |=> strobe_oe_b_ff && !strobe_release_ff ##1 !strobe_release_ff)
    else $error("strobe driven without locked loop");
  a_strobe_release: assert property (
    (rd_go && dll_locked && read_latency_cycles == 6'h0b) ##1
    ((!rd_go && dll_locked && $stable(read_latency_cycles))[*7] ##1
     (!rd_go && dll_locked)[*7]) |-> ##1 strobe_release_ff && !$past(strobe_oe_b_ff))
    else $error("strobe not released at latency plus four");

  c_col_err: cover property (col_go ##1 col_gap_err_ff);
  c_faw_err: cover property (faw_err_ff);
  c_release: cover property (strobe_release_ff);
  c_wtr_err: cover property (wr_to_rd_err_ff);

endmodule

// ---- verification/bgcs_ctrl_model.sv ----
// Behavioural memory controller that issues decoded commands to the spacing block.
// Assumes the caller picks the spacing; a command is driven at a falling edge and held one cycle.
`timescale 1ns/100ps
module bgcs_ctrl_model (
  // Command clock.
  input wire logic clock,
  // Decoded command port.
  output logic cmd_valid,
  output bgcs_pkg::bgcs_cmd_e cmd_op,
  output logic [1:0] group_select,
  output logic [1:0] bank_select
);
  import bgcs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Idle state at time zero: no command on the port.
  initial begin
    cmd_valid = 1'b0;
    cmd_op = CMD_NOP;
    group_select = 2'h0;
    bank_select = 2'h0;
  end

  // Drives one command for one cycle. When idle the lines show the inverse of
  // the last value, so a design that samples them outside a command sees junk.
  task automatic send(input bgcs_cmd_e op, input logic [1:0] grp, input logic [1:0] bank);
    @(negedge clock);
    cmd_valid = 1'b1;
    cmd_op = op;
    group_select = grp;
    bank_select = bank;
    @(negedge clock);
    cmd_valid = 1'b0;
    cmd_op = bgcs_cmd_e'(~op);
    group_select = ~grp;
    bank_select = ~bank;
  endtask
endmodule

// ---- verification/bgcs_spacing_tb.sv ----
// Self-checking bench for the bank group spacing block.
// Assumes the controller model drives commands; the bench drives configuration levels.
`timescale 1ns/100ps
module bgcs_spacing_tb;
  import bgcs_pkg::*;

  // Odd long column gap, so that rounding under the long preamble shows.
  localparam int COL_S = 4;
  localparam int COL_L = 5;
  localparam int FAW = 20;
  localparam int RL = 11;

  // Clock, reset and configuration levels.
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic x16_mode = 1'b0;
  logic page_2k = 1'b0;
  logic preamble_2t = 1'b0;
  logic dll_locked = 1'b1;
  logic [5:0] read_latency_cycles = 6'(RL);
  logic [5:0] write_latency_cycles = 6'h04;
  // Command port, driven by the controller model.
  logic cmd_valid;
  bgcs_cmd_e cmd_op;
  logic [1:0] group_select;
  logic [1:0] bank_select;
  // Observed outputs.
  logic [1:0] group_index_ff;
  logic [3:0] bank_index_ff;
  logic col_gap_err_ff, act_gap_err_ff, wr_to_rd_err_ff, faw_err_ff;
  logic strobe_oe_b_ff, strobe_release_ff;
  int fail_count = 0;
  int cmp_count = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // A 5 ns command clock.
  always #2.5 clock = ~clock;

  bgcs_ctrl_model bgcs_ctrl_model_i (.clock(clock), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .group_select(group_select), .bank_select(bank_select));

  bgcs_spacing #(.COL_S_CYC(COL_S), .COL_L_CYC(COL_L), .FAW_CYC(FAW)) bgcs_spacing_i (
    .clock(clock), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .group_select(group_select), .bank_select(bank_select), .x16_mode(x16_mode),
    .page_2k(page_2k), .preamble_2t(preamble_2t), .dll_locked(dll_locked),
    .read_latency_cycles(read_latency_cycles), .write_latency_cycles(write_latency_cycles),
    .group_index_ff(group_index_ff), .bank_index_ff(bank_index_ff),
    .col_gap_err_ff(col_gap_err_ff), .act_gap_err_ff(act_gap_err_ff),
    .wr_to_rd_err_ff(wr_to_rd_err_ff), .faw_err_ff(faw_err_ff),
    .strobe_oe_b_ff(strobe_oe_b_ff), .strobe_release_ff(strobe_release_ff));

  ////////////////////////////////////////////////////////////////////////////////
  // Compares one value and reports a mismatch at once.
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask

  // Two commands a given gap apart; flags are {col, act, wr_to_rd, faw}.
  // The long quiet lets every age timer saturate, so earlier cases cannot leak in.
  task automatic pair(input bgcs_cmd_e op1, input logic [1:0] g1, input bgcs_cmd_e op2,
                      input logic [1:0] g2, input int gap, input logic [3:0] exp);
    repeat (260) @(negedge clock);
    bgcs_ctrl_model_i.send(op1, g1, 2'h0);
    repeat (gap - 2) @(negedge clock);
    // The send returns in the cycle after the second command, while the pulse stands.
    bgcs_ctrl_model_i.send(op2, g2, 2'h1);
    check("error flags", {4'h0, exp},
          {4'h0, col_gap_err_ff, act_gap_err_ff, wr_to_rd_err_ff, faw_err_ff});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Column gaps at their boundaries, the long gap with both preamble settings.
  task automatic t_col;
    for (int p = 0; p < 2; p++) begin
      preamble_2t = p[0];
      pair(CMD_RD, 2'h0, CMD_WR, 2'h0, COL_L + p - 1, 4'h8);
      pair(CMD_RD, 2'h0, CMD_RD, 2'h0, COL_L + p, 4'h0);
    end
    preamble_2t = 1'b0;
    pair(CMD_RD, 2'h1, CMD_WR, 2'h2, COL_S - 1, 4'h8);
    pair(CMD_RD, 2'h1, CMD_RD, 2'h2, COL_S, 4'h0);
  endtask

  // Activate gaps for both page sizes; the ns figures stay below four cycles.
  task automatic t_act;
    for (int pg = 0; pg < 2; pg++) begin
      page_2k = pg[0];
      pair(CMD_ACT, 2'h0, CMD_ACT, 2'h1, 3, 4'h4);
      pair(CMD_ACT, 2'h0, CMD_ACT, 2'h1, 4, 4'h0);
      pair(CMD_ACT, 2'h2, CMD_ACT, 2'h2, 3, 4'h4);
      pair(CMD_ACT, 2'h2, CMD_ACT, 2'h2, 4, 4'h0);
    end
    page_2k = 1'b0;
  endtask

  // Write to read, counted from the internal write start at latency plus four.
  task automatic t_wtr;
    pair(CMD_WR, 2'h0, CMD_RD, 2'h1, 4 + 4 + 1, 4'h2);
    pair(CMD_WR, 2'h0, CMD_RD, 2'h1, 4 + 4 + 2, 4'h0);
    pair(CMD_WR, 2'h3, CMD_RD, 2'h3, 4 + 4 + 3, 4'h2);
    pair(CMD_WR, 2'h3, CMD_RD, 2'h3, 4 + 4 + 4, 4'h0);
    pair(CMD_WR, 2'h3, CMD_RD, 2'h3, 2, 4'ha);
    // A longer write latency moves the internal write start along with it.
    write_latency_cycles = 6'h09;
    pair(CMD_WR, 2'h2, CMD_RD, 2'h0, 9 + 4 + 1, 4'h2);
    pair(CMD_WR, 2'h2, CMD_RD, 2'h0, 9 + 4 + 2, 4'h0);
    write_latency_cycles = 6'h04;
  endtask

  // Four activates four cycles apart, then a fifth after a chosen gap.
  task automatic faw_case(input int last, input logic [3:0] exp);
    repeat (260) @(negedge clock);
    for (int i = 0; i < 4; i++) begin
      bgcs_ctrl_model_i.send(CMD_ACT, 2'(i), 2'h0);
      repeat (2) @(negedge clock);
    end
    repeat (last - 4) @(negedge clock);
    bgcs_ctrl_model_i.send(CMD_ACT, 2'h0, 2'h1);
    check("error flags", {4'h0, exp},
          {4'h0, col_gap_err_ff, act_gap_err_ff, wr_to_rd_err_ff, faw_err_ff});
  endtask

  task automatic t_faw;
    faw_case(4, 4'h1);
    faw_case(FAW - 12, 4'h0);
  endtask

  // Group folding: groups 1 and 3 are one group only in the x16 layout.
  task automatic t_groups;
    x16_mode = 1'b1;
    pair(CMD_RD, 2'h1, CMD_RD, 2'h3, COL_S, 4'h8);
    check("group index", 8'h01, {6'h0, group_index_ff});
    check("bank index", 8'h05, {4'h0, bank_index_ff});
    x16_mode = 1'b0;
    pair(CMD_RD, 2'h1, CMD_RD, 2'h3, COL_S, 4'h0);
    check("group index", 8'h03, {6'h0, group_index_ff});
    check("bank index", 8'h0d, {4'h0, bank_index_ff});
  endtask

  // Strobe drive and release after a read, with and without a locked loop.
  task automatic t_strobe;
    logic drive;
    logic rel;
    for (int lk = 0; lk < 2; lk++) begin
      dll_locked = lk[0];
      repeat (30) @(negedge clock);
      // The send returns in cycle one after the read; cycle k is seen before the k-th wait.
      bgcs_ctrl_model_i.send(CMD_RD, 2'h0, 2'h0);
      for (int k = 1; k <= RL + 5; k++) begin
        drive = (lk == 1 && k >= RL && k <= RL + 3);
        rel = (lk == 1 && k == RL + 4);
        check("strobe enable", {7'h0, !drive}, {7'h0, strobe_oe_b_ff});
        check("strobe release", {7'h0, rel}, {7'h0, strobe_release_ff});
        @(negedge clock);
      end
    end
    dll_locked = 1'b1;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Single exit point of the run.
  task automatic give_verdict;
    if (fail_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // The scenarios need about 6800 cycles; the limit leaves ample margin.
  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    give_verdict();
  end

  // Main sequence: eight cycles of reset, then every scenario in turn.
  initial begin
    repeat (8) @(negedge clock);
    rst_b = 1'b1;
    t_col();
    t_act();
    t_wtr();
    t_faw();
    t_groups();
    t_strobe();
    give_verdict();
  end
endmodule
